// file: inc/aef_pkg.sv
// Shared constants for the converter event flag and register map block
package aef_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] AEF_OFF_STATUS = 8'h00;
  localparam logic [7:0] AEF_OFF_IRQ_EN = 8'h04;
  localparam logic [7:0] AEF_OFF_CMD = 8'h08;
  localparam logic [7:0] AEF_OFF_CFG_A = 8'h0c;
  localparam logic [7:0] AEF_OFF_CFG_B = 8'h10;
  localparam logic [7:0] AEF_OFF_SMP = 8'h14;
  localparam logic [7:0] AEF_OFF_WIN_CTRL = 8'h18;
  localparam logic [7:0] AEF_OFF_WIN_THR = 8'h1c;
  localparam logic [7:0] AEF_OFF_CHSEL_LO = 8'h2c;
  localparam logic [7:0] AEF_OFF_CHSEL_HI = 8'h30;
  localparam logic [7:0] AEF_OFF_FIFO = 8'h4c;

  // ---------------------------------------------------------------------
  // Status and enable bit positions (same layout in both registers)
  // ---------------------------------------------------------------------
  localparam int unsigned AEF_B_READY = 0;
  localparam int unsigned AEF_B_SAMPLE = 1;
  localparam int unsigned AEF_B_CONV = 2;
  localparam int unsigned AEF_B_SEQ = 3;
  localparam int unsigned AEF_B_OVERRUN = 4;
  localparam int unsigned AEF_B_FULL = 5;
  localparam int unsigned AEF_B_EMPTY = 6;
  localparam int unsigned AEF_B_ALARM = 7;

  // ---------------------------------------------------------------------
  // Command bits
  // ---------------------------------------------------------------------
  localparam int unsigned AEF_C_ON = 0;
  localparam int unsigned AEF_C_OFF = 1;
  localparam int unsigned AEF_C_GO = 2;
  localparam int unsigned AEF_C_HALT = 3;

  // ---------------------------------------------------------------------
  // Window control and threshold fields
  // ---------------------------------------------------------------------
  localparam int unsigned AEF_W_EN = 7;
  localparam int unsigned AEF_W_SGL = 6;
  localparam int unsigned AEF_W_CH_LSB = 0;
  localparam int unsigned AEF_CH_W = 4;
  localparam int unsigned AEF_THR_HI_LSB = 16;
  localparam int unsigned AEF_THR_LO_LSB = 0;
  localparam int unsigned AEF_VAL_W = 12;
  localparam int unsigned AEF_FIFO_W = 16;

  // ---------------------------------------------------------------------
  // Writable masks and reset values
  // ---------------------------------------------------------------------
  localparam logic [31:0] AEF_FLAG_MASK = 32'h0000_009f;
  localparam logic [31:0] AEF_IRQ_EN_MASK = 32'h0000_009f;
  localparam logic [31:0] AEF_WIN_CTRL_MASK = 32'h0000_00cf;
  localparam logic [31:0] AEF_WIN_THR_MASK = 32'h0fff_0fff;
  localparam logic [31:0] AEF_RST_VAL = 32'h0000_0000;
  localparam logic [3:0] AEF_CMD_RST = 4'h0;

  // ---------------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------------
  localparam logic [1:0] AEF_RESP_OKAY = 2'b00;
  localparam logic [1:0] AEF_RESP_DECERR = 2'b11;

endpackage

// file: rtl/aef_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into access pulses
module aef_axil_slave
  import aef_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DATA_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_pulse,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [DATA_W/8-1:0] wr_strb,
  input wire logic wr_err,
  output logic rd_pulse,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_err
);

  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [DATA_W-1:0] w_data_r, w_data_nxt;
  logic [DATA_W/8-1:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;

  // Address and data are held separately so either may arrive first
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign wr_pulse = aw_held_r && w_held_r && !bvalid_r;
  assign wr_addr = aw_addr_r;
  assign wr_data = w_data_r;
  assign wr_strb = w_strb_r;
  assign arready = !rvalid_r;
  assign rd_pulse = arvalid && !rvalid_r;
  assign rd_addr = araddr;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid && awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (wr_pulse) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_err ? AEF_RESP_DECERR : AEF_RESP_OKAY;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_pulse) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_data;
      rresp_nxt = rd_err ? AEF_RESP_DECERR : AEF_RESP_OKAY;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= AEF_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= AEF_RESP_OKAY;
      rdata_r <= '0;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

endmodule

// file: rtl/aef_top.sv
// Converter event flags, interrupt gating and register map
//
// Added by the designer: the AXI4-Lite interface to the registers.
module aef_top
  import aef_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DATA_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic conv_ready_evt,
  input wire logic sample_done_evt,
  input wire logic conv_done_evt,
  input wire logic [AEF_CH_W-1:0] conv_chan,
  input wire logic [AEF_VAL_W-1:0] conv_value,
  input wire logic seq_done_evt,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic [AEF_FIFO_W-1:0] fifo_rdata,
  input wire logic go_clear,
  input wire logic halt_clear,
  input wire logic off_done,
  output logic fifo_rd_pulse,
  output logic irq,
  output logic converter_on_cmd,
  output logic converter_off_cmd,
  output logic conversion_go_cmd,
  output logic conversion_halt_cmd,
  output logic [DATA_W-1:0] conversion_config_a,
  output logic [DATA_W-1:0] conversion_config_b,
  output logic [DATA_W-1:0] sample_time,
  output logic [DATA_W-1:0] window_control,
  output logic [DATA_W-1:0] window_thresholds,
  output logic [DATA_W-1:0] channel_select_low,
  output logic [DATA_W-1:0] channel_select_high
);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Every offset in the map, used by both the write and the read decode
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      AEF_OFF_STATUS, AEF_OFF_IRQ_EN, AEF_OFF_CMD, AEF_OFF_CFG_A,
      AEF_OFF_CFG_B, AEF_OFF_SMP, AEF_OFF_WIN_CTRL, AEF_OFF_WIN_THR,
      AEF_OFF_CHSEL_LO, AEF_OFF_CHSEL_HI, AEF_OFF_FIFO: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [DATA_W-1:0] strb_mask(
    input logic [DATA_W/8-1:0] s
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W / 8; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // Byte-enabled merge that keeps reserved bits at their reset value
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [DATA_W-1:0] bytes,
    input logic [DATA_W-1:0] keep
  );
    return ((old_v & ~bytes) | (new_v & bytes)) & keep;
  endfunction

  // -----------------------------------------------------------------------
  // Bus front end
  // -----------------------------------------------------------------------
  logic wr_pulse, rd_pulse;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [DATA_W/8-1:0] wr_strb;
  logic wr_err, rd_err;

  // Protection bits are not decoded: all privilege levels get through
  aef_axil_slave #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_pulse(rd_pulse),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_err = !addr_mapped(wr_addr);
  assign rd_err = !addr_mapped(rd_addr);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [DATA_W-1:0] flags_r, flags_nxt;
  logic [DATA_W-1:0] irq_en_r, irq_en_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [DATA_W-1:0] cfg_a_r, cfg_a_nxt, cfg_b_r, cfg_b_nxt;
  logic [DATA_W-1:0] smp_r, smp_nxt, win_ctrl_r, win_ctrl_nxt;
  logic [DATA_W-1:0] win_thr_r, win_thr_nxt;
  logic [DATA_W-1:0] chsel_lo_r, chsel_lo_nxt, chsel_hi_r, chsel_hi_nxt;
  logic irq_r, irq_nxt;

  logic [DATA_W-1:0] bytes, w1c, set_v, status_v;
  logic wr_hit_status, wr_hit_cmd, fifo_pop;
  logic win_scope, win_out;
  logic [AEF_VAL_W-1:0] thr_hi, thr_lo;

  assign bytes = strb_mask(wr_strb);
  assign wr_hit_status = wr_pulse && (wr_addr == AEF_OFF_STATUS);
  assign wr_hit_cmd = wr_pulse && (wr_addr == AEF_OFF_CMD);
  assign fifo_pop = rd_pulse && (rd_addr == AEF_OFF_FIFO);
  assign fifo_rd_pulse = fifo_pop;

  // -----------------------------------------------------------------------
  // Event detection
  // -----------------------------------------------------------------------
  assign thr_hi = win_thr_r[AEF_THR_HI_LSB +: AEF_VAL_W];
  assign thr_lo = win_thr_r[AEF_THR_LO_LSB +: AEF_VAL_W];
  assign win_scope = win_ctrl_r[AEF_W_EN] && (!win_ctrl_r[AEF_W_SGL] ||
    (conv_chan == win_ctrl_r[AEF_W_CH_LSB +: AEF_CH_W]));
  assign win_out = (conv_value > thr_hi) || (conv_value < thr_lo);

  always_comb begin
    set_v = '0;
    set_v[AEF_B_READY] = conv_ready_evt && cmd_r[AEF_C_ON];
    set_v[AEF_B_SAMPLE] = sample_done_evt;
    set_v[AEF_B_CONV] = conv_done_evt;
    set_v[AEF_B_SEQ] = seq_done_evt;
    set_v[AEF_B_OVERRUN] = conv_done_evt && fifo_full;
    set_v[AEF_B_ALARM] = conv_done_evt && win_scope && win_out;
  end

  // -----------------------------------------------------------------------
  // Flags: write one clears, a new event in the same cycle wins
  // -----------------------------------------------------------------------
  always_comb begin
    w1c = wr_hit_status ? (wr_data & bytes & AEF_FLAG_MASK) : '0;
    if (fifo_pop) begin
      w1c[AEF_B_CONV] = 1'b1;
    end
    flags_nxt = ((flags_r & ~w1c) | set_v) & AEF_FLAG_MASK;
  end

  // Fifo levels come straight from the result store, never latched
  always_comb begin
    status_v = flags_r;
    status_v[AEF_B_FULL] = fifo_full;
    status_v[AEF_B_EMPTY] = fifo_empty;
  end

  // -----------------------------------------------------------------------
  // Command bits: software sets, hardware completion clears
  // -----------------------------------------------------------------------
  always_comb begin
    cmd_nxt = cmd_r;
    if (halt_clear) begin
      cmd_nxt[AEF_C_HALT] = 1'b0;
      cmd_nxt[AEF_C_GO] = 1'b0;
    end
    if (go_clear) begin
      cmd_nxt[AEF_C_GO] = 1'b0;
    end
    if (off_done) begin
      cmd_nxt[AEF_C_OFF] = 1'b0;
      cmd_nxt[AEF_C_ON] = 1'b0;
    end
    // Illegal sequences are dropped rather than half executed
    if (wr_hit_cmd && wr_strb[0]) begin
      if (wr_data[AEF_C_ON] && (cmd_r == AEF_CMD_RST)) begin
        cmd_nxt[AEF_C_ON] = 1'b1;
      end
      if (wr_data[AEF_C_GO] && cmd_r[AEF_C_ON] && !cmd_r[AEF_C_OFF]) begin
        cmd_nxt[AEF_C_GO] = 1'b1;
      end
      if (wr_data[AEF_C_HALT] && cmd_r[AEF_C_GO] && !cmd_r[AEF_C_OFF]) begin
        cmd_nxt[AEF_C_HALT] = 1'b1;
      end
      if (wr_data[AEF_C_OFF] && cmd_r[AEF_C_ON] && !cmd_r[AEF_C_GO]) begin
        cmd_nxt[AEF_C_OFF] = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Plain read/write registers
  // -----------------------------------------------------------------------
  always_comb begin
    irq_en_nxt = irq_en_r;
    cfg_a_nxt = cfg_a_r;
    cfg_b_nxt = cfg_b_r;
    smp_nxt = smp_r;
    win_ctrl_nxt = win_ctrl_r;
    win_thr_nxt = win_thr_r;
    chsel_lo_nxt = chsel_lo_r;
    chsel_hi_nxt = chsel_hi_r;
    if (wr_pulse) begin
      unique case (wr_addr)
        AEF_OFF_IRQ_EN:
          irq_en_nxt = merge(irq_en_r, wr_data, bytes, AEF_IRQ_EN_MASK);
        AEF_OFF_CFG_A:
          cfg_a_nxt = merge(cfg_a_r, wr_data, bytes, '1);
        AEF_OFF_CFG_B:
          cfg_b_nxt = merge(cfg_b_r, wr_data, bytes, '1);
        AEF_OFF_SMP:
          smp_nxt = merge(smp_r, wr_data, bytes, '1);
        AEF_OFF_WIN_CTRL:
          win_ctrl_nxt = merge(win_ctrl_r, wr_data, bytes, AEF_WIN_CTRL_MASK);
        AEF_OFF_WIN_THR:
          win_thr_nxt = merge(win_thr_r, wr_data, bytes, AEF_WIN_THR_MASK);
        AEF_OFF_CHSEL_LO:
          chsel_lo_nxt = merge(chsel_lo_r, wr_data, bytes, '1);
        AEF_OFF_CHSEL_HI:
          chsel_hi_nxt = merge(chsel_hi_r, wr_data, bytes, '1);
        default: ;
      endcase
    end
  end

  // Registered from next values so the line changes on the same edge as the flag
  always_comb begin
    irq_nxt = |(flags_nxt & irq_en_nxt & AEF_FLAG_MASK);
  end

  // -----------------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      AEF_OFF_STATUS: rd_data = status_v;
      AEF_OFF_IRQ_EN: rd_data = irq_en_r;
      AEF_OFF_CMD: rd_data = {{(DATA_W-4){1'b0}}, cmd_r};
      AEF_OFF_CFG_A: rd_data = cfg_a_r;
      AEF_OFF_CFG_B: rd_data = cfg_b_r;
      AEF_OFF_SMP: rd_data = smp_r;
      AEF_OFF_WIN_CTRL: rd_data = win_ctrl_r;
      AEF_OFF_WIN_THR: rd_data = win_thr_r;
      AEF_OFF_CHSEL_LO: rd_data = chsel_lo_r;
      AEF_OFF_CHSEL_HI: rd_data = chsel_hi_r;
      AEF_OFF_FIFO: rd_data = {{(DATA_W-AEF_FIFO_W){1'b0}}, fifo_rdata};
      default: rd_data = '0;
    endcase
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= AEF_RST_VAL;
      irq_en_r <= AEF_RST_VAL;
      cmd_r <= AEF_CMD_RST;
      cfg_a_r <= AEF_RST_VAL;
      cfg_b_r <= AEF_RST_VAL;
      smp_r <= AEF_RST_VAL;
      win_ctrl_r <= AEF_RST_VAL;
      win_thr_r <= AEF_RST_VAL;
      chsel_lo_r <= AEF_RST_VAL;
      chsel_hi_r <= AEF_RST_VAL;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      irq_en_r <= irq_en_nxt;
      cmd_r <= cmd_nxt;
      cfg_a_r <= cfg_a_nxt;
      cfg_b_r <= cfg_b_nxt;
      smp_r <= smp_nxt;
      win_ctrl_r <= win_ctrl_nxt;
      win_thr_r <= win_thr_nxt;
      chsel_lo_r <= chsel_lo_nxt;
      chsel_hi_r <= chsel_hi_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;
  assign converter_on_cmd = cmd_r[AEF_C_ON];
  assign converter_off_cmd = cmd_r[AEF_C_OFF];
  assign conversion_go_cmd = cmd_r[AEF_C_GO];
  assign conversion_halt_cmd = cmd_r[AEF_C_HALT];
  assign conversion_config_a = cfg_a_r;
  assign conversion_config_b = cfg_b_r;
  assign sample_time = smp_r;
  assign window_control = win_ctrl_r;
  assign window_thresholds = win_thr_r;
  assign channel_select_low = chsel_lo_r;
  assign channel_select_high = chsel_hi_r;

endmodule

// file: verification/aef_conv_model.sv
// Converter side model: result store and completion pulses
module aef_conv_model #(
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_req,
  input wire logic [11:0] req_value,
  input wire logic pop,
  output logic conv_done_evt,
  output logic [11:0] conv_value,
  output logic fifo_empty,
  output logic fifo_full,
  output logic [15:0] fifo_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] q[$];
  logic [15:0] idle_r = 16'h0;
  // A result enters the store one edge after its pulse, so the block
  // sees the full level from before that conversion
  always @(posedge aclk) begin
    if (!aresetn) begin
      q.delete();
      conv_done_evt <= 1'b0;
    end else begin
      conv_done_evt <= conv_req;
      conv_value <= req_value;
      if (pop && q.size() > 0)
        void'(q.pop_front());
      if (conv_done_evt && q.size() < DEPTH)
        q.push_back(conv_value);
    end
    idle_r <= idle_r + 16'h1357;
    fifo_empty <= (q.size() == 0);
    fifo_full <= (q.size() >= DEPTH);
    fifo_rdata <= (q.size() > 0) ? {4'h0, q[0]} : idle_r;
  end
endmodule

// file: verification/aef_top_monitor.sv
// Port checker for the converter event block
module aef_monitor
  import aef_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DATA_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic conv_ready_evt,
  input wire logic sample_done_evt,
  input wire logic conv_done_evt,
  input wire logic seq_done_evt,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic [AEF_FIFO_W-1:0] fifo_rdata,
  input wire logic fifo_rd_pulse,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic seen_r;
  logic seen_nxt;
  logic rd_take;
  assign rd_take = arvalid && arready;
  // No flag can be set before the first event, so irq must stay low
  always_comb begin
    seen_nxt = seen_r | conv_ready_evt | sample_done_evt;
    seen_nxt = seen_nxt | conv_done_evt | seq_done_evt;
    if (!aresetn)
      seen_nxt = 1'b0;
  end
  always_ff @(posedge aclk) begin
    seen_r <= seen_nxt;
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_ans; rd_take |=> rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_pop; fifo_rd_pulse == (rd_take && araddr == 8'h4c); endproperty
  a_pop: assert property (p_pop) else $error("bad store pop");
  property p_fifo;
    fifo_rd_pulse |=> rdata == {16'h0, $past(fifo_rdata)};
  endproperty
  a_fifo: assert property (p_fifo) else $error("bad store data");
  property p_live;
    rd_take && araddr == 8'h00 |=>
      rdata[6] == $past(fifo_empty) && rdata[5] == $past(fifo_full);
  endproperty
  a_live: assert property (p_live) else $error("bad level bits");
  property p_ien;
    rd_take && araddr == 8'h04 |=> rdata[31:8] == '0 && rdata[6:5] == 2'b00;
  endproperty
  a_ien: assert property (p_ien) else $error("enable reserved set");
  property p_cmd; rd_take && araddr == 8'h08 |=> rresp == 2'b00; endproperty
  a_cmd: assert property (p_cmd) else $error("command read error");
  property p_undef;
    rd_take && araddr == 8'h20 |=> rresp == 2'b11 && rdata == '0;
  endproperty
  a_undef: assert property (p_undef) else $error("bad unmapped read");
  property p_quiet; !seen_r |-> !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("irq with no event");
  c_overrun: cover property (conv_done_evt && fifo_full);
  c_irq: cover property ($rose(irq));
  c_pop: cover property (fifo_rd_pulse);
endmodule

bind aef_top aef_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
  .aclk, .aresetn, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .conv_ready_evt, .sample_done_evt, .conv_done_evt, .seq_done_evt,
  .fifo_empty, .fifo_full, .fifo_rdata, .fifo_rd_pulse, .irq
);

// file: verification/adc_event_flags_and_map_tb.sv
// Self-checking bench for the converter event block
module adc_event_flags_and_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aef_pkg::*;
  localparam int DEPTH = 4;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, pop, cdone, fe, ff;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h9a542586, d, rdata;
  logic [3:0] wstrb = 4'hf, ev = 4'h0;
  logic [1:0] bresp, rresp;
  logic [11:0] req_v = 12'h000, cval, v;
  logic [15:0] frd;
  logic [11:0] q[$];
  logic [11:0] cv[4] = '{12'h900, 12'h800, 12'h100, 12'h0ff};
  logic [7:0] ra[8] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                        8'h2c, 8'h30};
  logic [31:0] rm[8] = '{32'h9f, '1, '1, '1, 32'hcf, 32'h0fff0fff, '1, '1};
  int bits[3] = '{0, 1, 3};
  int bad_count = 0, cmp_count = 0;

  aef_conv_model #(.DEPTH(DEPTH)) u_conv (
    .aclk, .aresetn, .conv_req(ev[2]), .req_value(req_v), .pop,
    .conv_done_evt(cdone), .conv_value(cval), .fifo_empty(fe),
    .fifo_full(ff), .fifo_rdata(frd)
  );
  aef_top dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready,
    .conv_ready_evt(ev[0]), .sample_done_evt(ev[1]), .seq_done_evt(ev[3]),
    .conv_done_evt(cdone), .conv_chan(4'h0), .conv_value(cval),
    .fifo_empty(fe), .fifo_full(ff), .fifo_rdata(frd), .go_clear(1'b0),
    .halt_clear(1'b0), .off_done(1'b0), .fifo_rd_pulse(pop), .irq,
    .converter_on_cmd(), .converter_off_cmd(), .conversion_go_cmd(),
    .conversion_halt_cmd(), .conversion_config_a(),
    .conversion_config_b(), .sample_time(), .window_control(),
    .window_thresholds(), .channel_select_low(), .channel_select_high()
  );
  initial forever #10 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Window is exclusive: values equal to a threshold raise no alarm
  function automatic logic out_win(input logic [11:0] x);
    return x > 12'h800 || x < 12'h100;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] e = 2'b00);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    {ta, tw} = 2'b00;
    do begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && tw));
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(e));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'b00);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic pulse(input int b);
    @(posedge aclk);
    ev <= 4'h1 << b;
    @(posedge aclk);
    ev <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic chki(input logic e);
    @(posedge aclk);
    chk(32'(irq), 32'(e));
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h40);
    rchk(8'h04, 32'h0);
    foreach (ra[i]) begin
      d = xs();
      wchk(ra[i], d);
      rchk(ra[i], d & rm[i]);
    end
    wchk(8'h20, xs(), 2'b11);
    rchk(8'h20, 32'h0, 2'b11);
    wchk(8'h18, 32'h0);
    $display("register map test done");
    wchk(8'h04, 32'h0);
    pulse(0);
    rchk(8'h00, 32'h40);
    wchk(8'h08, 32'h1);
    rchk(8'h08, 32'h1);
    foreach (bits[i]) begin
      wchk(8'h04, 32'h1 << bits[i]);
      pulse(bits[i]);
      chki(1'b1);
      wchk(8'h00, 32'h0);
      rchk(8'h00, 32'h40 | 32'h1 << bits[i]);
      wchk(8'h00, 32'h1 << bits[i]);
      chki(1'b0);
      wchk(8'h04, 32'h0);
      pulse(bits[i]);
      chki(1'b0);
      wchk(8'h00, 32'hff);
    end
    $display("flag test done");
    wchk(8'h04, 32'h10);
    repeat (DEPTH) begin
      v = 12'(xs());
      q.push_back(v);
      req_v <= v;
      pulse(2);
    end
    chki(1'b0);
    rchk(8'h00, 32'h24);
    pulse(2);
    chki(1'b1);
    rchk(8'h00, 32'h34);
    wchk(8'h00, 32'h14);
    rchk(8'h00, 32'h20);
    foreach (q[i]) rchk(8'h4c, {20'h0, q[i]});
    rchk(8'h00, 32'h40);
    $display("overrun test done");
    wchk(8'h1c, 32'h0800_0100);
    wchk(8'h18, 32'h80);
    wchk(8'h04, 32'h80);
    for (int i = 0; i < 12; i++) begin
      v = (i < 4) ? cv[i] : 12'(xs());
      req_v <= v;
      pulse(2);
      chki(out_win(v));
      rchk(8'h00, {24'h0, out_win(v), 7'h04});
      rchk(8'h4c, {20'h0, v});
      rchk(8'h00, {24'h0, out_win(v), 7'h40});
      wchk(8'h00, 32'h80);
    end
    // Single channel guard: channel 0 matches the tied channel, 5 does not
    for (int i = 0; i < 2; i++) begin
      wchk(8'h18, 32'hc0 | 32'(5 * i));
      req_v <= 12'hfff;
      pulse(2);
      chki(i == 0);
      rchk(8'h4c, 32'hfff);
      wchk(8'h00, 32'h80);
    end
    $display("window test done");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    final_report();
  end
endmodule
